// File: logic/pdc_controller.sv
`timescale 1ns/1ps
module pdc_controller
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Avalon-MM register slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Memory master
    output logic mem_read_out,
    output logic mem_write_out,
    output logic [31:0] mem_address_out,
    output logic [15:0] mem_writedata_out,
    output logic mem_wide_out,
    input wire logic [15:0] mem_readdata_in,
    input wire logic mem_waitrequest_in,
    // Peripheral receive paths
    input wire logic [3:0] rx_valid_in,
    input wire logic [3:0][15:0] rx_data_in,
    output logic [3:0] rx_ready_out,
    // Peripheral transmit paths
    input wire logic [3:0] tx_ready_in,
    output logic [3:0] tx_valid_out,
    output logic [15:0] tx_data_out,
    // Transfer size per peripheral, 1 = halfword
    input wire logic [3:0] wide_in,
    // Interrupt
    output logic irq_out
);

    pdc_state_s q;
    pdc_state_s d;
    logic [7:0] pend;
    logic [3:0] grant;
    logic [1:0] ap;
    logic [2:0] ar;

    // Lowest index wins; bit 3 flags a hit
    function automatic logic [3:0] pick(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = PDC_NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, i[2:0]};
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] step(input logic wide);
        return wide ? PDC_STEP_WIDE : PDC_STEP_NARROW;
    endfunction

    assign ap = avs_address_in[4:3];
    assign ar = avs_address_in[2:0];

    always_comb begin
        for (int p = 0; p < PDC_NUM_PERIPH; p++) begin
            pend[2*p] = (q.cnt[2*p] != PDC_CNT_RESET) && rx_valid_in[p];
            pend[2*p+1] = (q.cnt[2*p+1] != PDC_CNT_RESET) && tx_ready_in[p];
        end
    end

    assign grant = pick(pend);

    always_comb begin
        d = q;
        // One wait cycle per access gives the read mux a full cycle
        d.ack = (avs_read_in || avs_write_in) && !q.ack;
        if (avs_read_in && !q.ack) begin
            case (ar)
                PDC_REG_RX_PTR: d.rdata = q.ptr[{ap, 1'b0}];
                PDC_REG_RX_CNT: d.rdata = {16'h0000, q.cnt[{ap, 1'b0}]};
                PDC_REG_TX_PTR: d.rdata = q.ptr[{ap, 1'b1}];
                PDC_REG_TX_CNT: d.rdata = {16'h0000, q.cnt[{ap, 1'b1}]};
                PDC_REG_EVT_STATUS: d.rdata = {30'h0, q.sts[2*ap +: 2]};
                PDC_REG_EVT_ENABLE: d.rdata = {30'h0, q.ena[2*ap +: 2]};
                default: d.rdata = PDC_READ_ZERO;
            endcase
        end
        if (avs_write_in && q.ack) begin
            case (ar)
                PDC_REG_RX_PTR: d.ptr[{ap, 1'b0}] = avs_writedata_in;
                PDC_REG_RX_CNT: d.cnt[{ap, 1'b0}] = avs_writedata_in[15:0];
                PDC_REG_TX_PTR: d.ptr[{ap, 1'b1}] = avs_writedata_in;
                PDC_REG_TX_CNT: d.cnt[{ap, 1'b1}] = avs_writedata_in[15:0];
                PDC_REG_EVT_CLEAR: d.sts[2*ap +: 2] = q.sts[2*ap +: 2] & ~avs_writedata_in[1:0];
                PDC_REG_EVT_ENABLE: d.ena[2*ap +: 2] = avs_writedata_in[1:0];
                default: d.rdata = q.rdata;
            endcase
        end
        // Engine runs after the bus so a completion beats a same-cycle write or clear
        case (q.st)
            PDC_IDLE: begin
                if (grant[3]) begin
                    d.ch = grant[2:0];
                    if (grant[0]) begin
                        d.st = PDC_RD_MEM;
                    end else begin
                        d.data = rx_data_in[grant[2:1]];
                        d.st = PDC_WR_MEM;
                    end
                end
            end
            PDC_RD_MEM: begin
                if (!mem_waitrequest_in) begin
                    d.data = mem_readdata_in;
                    d.st = PDC_PUSH;
                end
            end
            PDC_WR_MEM, PDC_PUSH: begin
                if ((q.st == PDC_WR_MEM && !mem_waitrequest_in) ||
                    (q.st == PDC_PUSH && tx_ready_in[q.ch[2:1]])) begin
                    d.ptr[q.ch] = q.ptr[q.ch] + step(wide_in[q.ch[2:1]]);
                    d.cnt[q.ch] = q.cnt[q.ch] - PDC_CNT_LAST;
                    if (q.cnt[q.ch] == PDC_CNT_LAST) begin
                        d.sts[q.ch] = 1'b1;
                    end
                    d.st = PDC_IDLE;
                end
            end
            default: d.st = PDC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q.st <= PDC_IDLE;
            q.ch <= 3'h0;
            q.data <= 16'h0000;
            q.ack <= 1'b0;
            q.rdata <= PDC_READ_ZERO;
            q.ptr <= {PDC_NUM_CH{PDC_PTR_RESET}};
            q.cnt <= {PDC_NUM_CH{PDC_CNT_RESET}};
            q.sts <= 8'h00;
            q.ena <= 8'h00;
        end else begin
            q <= d;
        end
    end

    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !q.ack;
    assign avs_readdata_out = q.rdata;
    assign mem_read_out = (q.st == PDC_RD_MEM);
    assign mem_write_out = (q.st == PDC_WR_MEM);
    assign mem_address_out = q.ptr[q.ch];
    assign mem_writedata_out = q.data;
    assign mem_wide_out = wide_in[q.ch[2:1]];
    assign tx_data_out = q.data;
    assign irq_out = |(q.sts & q.ena);

    always_comb begin
        for (int p = 0; p < PDC_NUM_PERIPH; p++) begin
            rx_ready_out[p] = (q.st == PDC_IDLE) && grant[3] && (grant[2:0] == 3'(2*p));
            tx_valid_out[p] = (q.st == PDC_PUSH) && (q.ch == 3'(2*p+1));
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    bus_one_wait_a: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("register access not answered after one wait cycle");

    ptr_step_a: assert property (
        (q.st == PDC_WR_MEM) && !mem_waitrequest_in && !wide_in[q.ch[2:1]] |=>
        q.ptr[$past(q.ch)] == $past(q.ptr[q.ch]) + 32'h1)
        else $error("pointer did not advance by one byte");

    cnt_step_a: assert property (
        (q.st == PDC_PUSH) && tx_ready_in[q.ch[2:1]] |=>
        q.cnt[$past(q.ch)] == $past(q.cnt[q.ch]) - 16'h1 && q.st == PDC_IDLE)
        else $error("count did not drop by one");

    end_event_a: assert property (
        (q.st == PDC_WR_MEM) && !mem_waitrequest_in && q.cnt[q.ch] == 16'h1 |=>
        q.sts[$past(q.ch)] && q.cnt[$past(q.ch)] == 16'h0)
        else $error("end of transfer not flagged");

    no_zero_grant_a: assert property (
        (q.st == PDC_IDLE) && grant[3] |-> q.cnt[grant[2:0]] != 16'h0 ##1 q.st != PDC_IDLE)
        else $error("channel with zero count granted");

    rx_hand_a: assert property (
        |rx_ready_out |-> $onehot(rx_ready_out) && |(rx_ready_out & rx_valid_in))
        else $error("receive accepted without valid data");

    tx_path_a: assert property (
        (q.st == PDC_RD_MEM) && !mem_waitrequest_in |=> |tx_valid_out && tx_data_out == $past(mem_readdata_in))
        else $error("read word not offered to the transmitter");

    mem_hold_a: assert property (
        mem_write_out && mem_waitrequest_in |=> mem_write_out && $stable(mem_address_out) && $stable(mem_writedata_out))
        else $error("memory write dropped while stalled");

    one_owner_a: assert property (
        $onehot0(tx_valid_out) && !(mem_read_out && mem_write_out))
        else $error("more than one channel active");

    // Engine sequencing and register access checks
    idle_quiet_a: assert property (
        (q.st == PDC_IDLE) |-> !mem_read_out && !mem_write_out)
        else $error("memory request outside a transfer");

    rd_hold_a: assert property (
        mem_read_out && mem_waitrequest_in |=> mem_read_out && $stable(mem_address_out))
        else $error("memory read dropped while stalled");

    rx_capture_a: assert property (
        (q.st == PDC_IDLE) && grant[3] && !grant[0] |=>
        mem_write_out && mem_writedata_out == $past(rx_data_in[grant[2:1]]))
        else $error("received word not written to memory");

    rx_addr_a: assert property (
        (q.st == PDC_IDLE) && grant[3] && !avs_write_in |=>
        mem_address_out == $past(q.ptr[grant[2:0]]))
        else $error("transfer not at channel pointer");

    tx_start_a: assert property (
        (q.st == PDC_IDLE) && grant[3] && grant[0] |=> mem_read_out)
        else $error("transmit grant did not read memory");

    grant_low_a: assert property (
        (q.st == PDC_IDLE) && pend[0] |-> grant == 4'h8)
        else $error("lowest pending channel not chosen");

    wide_step_a: assert property (
        (q.st == PDC_WR_MEM) && !mem_waitrequest_in && wide_in[q.ch[2:1]] |=>
        q.ptr[$past(q.ch)] == $past(q.ptr[q.ch]) + 32'h2)
        else $error("pointer did not advance by a halfword");

    tx_step_a: assert property (
        (q.st == PDC_PUSH) && tx_ready_in[q.ch[2:1]] && !wide_in[q.ch[2:1]] |=>
        q.ptr[$past(q.ch)] == $past(q.ptr[q.ch]) + 32'h1)
        else $error("transmit pointer did not advance");

    rd_ptr_hold_a: assert property (
        (q.st == PDC_RD_MEM) && !avs_write_in |=>
        q.ptr[$past(q.ch)] == $past(q.ptr[q.ch]))
        else $error("pointer moved before the word was delivered");

    wr_cnt_hold_a: assert property (
        (q.st == PDC_WR_MEM) && mem_waitrequest_in && !avs_write_in |=> $stable(q.cnt))
        else $error("count moved while memory stalled");

    push_hold_a: assert property (
        (q.st == PDC_PUSH) && !tx_ready_in[q.ch[2:1]] |=>
        (q.st == PDC_PUSH) && $stable(tx_data_out))
        else $error("transmit word dropped before taken");

    rx_irq_a: assert property (
        (q.st == PDC_WR_MEM) && !mem_waitrequest_in && q.cnt[q.ch] == 16'h1 &&
        q.ena[q.ch] && !avs_write_in |=> irq_out)
        else $error("enabled end of transfer raised no interrupt");

    tx_end_a: assert property (
        (q.st == PDC_PUSH) && tx_ready_in[q.ch[2:1]] && q.cnt[q.ch] == 16'h1 |=>
        q.sts[$past(q.ch)])
        else $error("transmit end not flagged");

    sts_sticky_a: assert property (
        !(avs_write_in && q.ack && ar == PDC_REG_EVT_CLEAR) |=>
        (q.sts & $past(q.sts)) == $past(q.sts))
        else $error("status bit lost without a clear");

    mem_owner_a: assert property (
        mem_write_out |-> tx_valid_out == 4'h0)
        else $error("transmit offered during a receive transfer");

    cnt_read_a: assert property (
        avs_read_in && avs_waitrequest_out && ar == PDC_REG_RX_CNT |=>
        avs_readdata_out == {16'h0000, $past(q.cnt[{ap, 1'b0}])})
        else $error("count read wrong");

    unmapped_read_a: assert property (
        avs_read_in && avs_waitrequest_out && ar == 3'h7 |=> avs_readdata_out == PDC_READ_ZERO)
        else $error("unmapped register read not zero");

    ena_write_a: assert property (
        avs_write_in && !avs_waitrequest_out && ar == PDC_REG_EVT_ENABLE |=>
        q.ena[2*$past(ap) +: 2] == $past(avs_writedata_in[1:0]))
        else $error("enable write not applied");

    ptr_write_a: assert property (
        avs_write_in && !avs_waitrequest_out && ar == PDC_REG_TX_PTR && (q.st == PDC_IDLE) |=>
        q.ptr[{$past(ap), 1'b1}] == $past(avs_writedata_in))
        else $error("pointer write not applied");

    cnt_write_a: assert property (
        avs_write_in && !avs_waitrequest_out && ar == PDC_REG_RX_CNT && (q.st == PDC_IDLE) |=>
        q.cnt[{$past(ap), 1'b0}] == $past(avs_writedata_in[15:0]))
        else $error("count write not applied");

    rx_done_c: cover property ((q.st == PDC_WR_MEM) && !mem_waitrequest_in && q.cnt[q.ch] == 16'h1);
    tx_done_c: cover property ((q.st == PDC_PUSH) && tx_ready_in[q.ch[2:1]] && q.cnt[q.ch] == 16'h1);
    irq_c: cover property ($rose(irq_out));
    stall_c: cover property (mem_write_out && mem_waitrequest_in [*3]);

endmodule

// File: logic/pdc_pkg.sv
// Notes on behaviour
// - Eight channels, serving only three serial transceivers and one SPI unit.
// - Each peripheral owns one receive channel and one transmit channel.
// - Channels move data between peripheral and memory with no processor help.
// - One programming moves a contiguous block up to 64K bytes or halfwords, no address reload.
// - Each channel holds a 32-bit address pointer and 16-bit count, software writable.
// - When a channel's count ends, its peripheral raises an end-of-transfer event.
// - Pointer and count registers sit inside the owning peripheral's register window.
package pdc_pkg;
    localparam int PDC_NUM_PERIPH = 4;
    localparam int PDC_NUM_CH = 8;
    localparam int PDC_DATA_W = 16;
    localparam int PDC_PTR_W = 32;
    localparam int PDC_CNT_W = 16;
    localparam int PDC_AW = 5;
    // Word index inside a peripheral window: address[4:3] peripheral, [2:0] register
    localparam logic [2:0] PDC_REG_RX_PTR = 3'h0;
    localparam logic [2:0] PDC_REG_RX_CNT = 3'h1;
    localparam logic [2:0] PDC_REG_TX_PTR = 3'h2;
    localparam logic [2:0] PDC_REG_TX_CNT = 3'h3;
    localparam logic [2:0] PDC_REG_EVT_STATUS = 3'h4;
    localparam logic [2:0] PDC_REG_EVT_CLEAR = 3'h5;
    localparam logic [2:0] PDC_REG_EVT_ENABLE = 3'h6;
    localparam logic [31:0] PDC_PTR_RESET = 32'h0;
    localparam logic [15:0] PDC_CNT_RESET = 16'h0;
    localparam logic [15:0] PDC_CNT_LAST = 16'h1;
    localparam logic [31:0] PDC_STEP_NARROW = 32'h1;
    localparam logic [31:0] PDC_STEP_WIDE = 32'h2;
    localparam logic [31:0] PDC_READ_ZERO = 32'h0;

    typedef enum logic [3:0] {
        PDC_IDLE = 4'h1,
        PDC_WR_MEM = 4'h2,
        PDC_RD_MEM = 4'h4,
        PDC_PUSH = 4'h8
    } pdc_state_e;

    typedef struct packed {
        pdc_state_e st;
        logic [2:0] ch;
        logic [15:0] data;
        logic ack;
        logic [31:0] rdata;
        logic [7:0][31:0] ptr;
        logic [7:0][15:0] cnt;
        logic [7:0] sts;
        logic [7:0] ena;
    } pdc_state_s;
endpackage

// File: tb/pdc_mem_model.sv
`timescale 1ns/1ps
module pdc_mem_model (
    // Bus from the controller
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [31:0] addr_in,
    input wire logic [15:0] wdata_in,
    // Answer
    output logic [15:0] rdata_out,
    output logic wait_out
);
    logic [15:0] mem [0:255];
    logic hold;
    initial begin
        hold = 1'b0;
        for (int i = 0; i < 256; i++)
            mem[i] = 16'hC000 + 16'(i);
    end
    // Slow mode stalls every request for one cycle
    assign wait_out = slow_in & (rd_in | wr_in) & ~hold;
    always @(posedge clk_in) begin
        hold <= (rd_in | wr_in) & wait_out;
        if (wr_in && !wait_out)
            mem[addr_in[7:0]] <= wdata_in;
    end
    // Off-request data is inverted so a stale capture shows up
    assign rdata_out = rd_in ? mem[addr_in[7:0]] : ~mem[addr_in[7:0]];
endmodule

// File: tb/peripheral_data_controller_tb_top.sv
`timescale 1ns/1ps
module peripheral_data_controller_tb_top;
    import pdc_pkg::*;
    logic core_clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0;
    logic [4:0] avs_address_in = 0;
    logic [31:0] avs_writedata_in = 0, avs_readdata_out, mem_address_out;
    logic avs_waitrequest_out, mem_read_out, mem_write_out, mem_wide_out, mem_waitrequest_in;
    logic [15:0] mem_writedata_out, mem_readdata_in, tx_data_out;
    logic [3:0] rx_valid_in = 0, rx_ready_out, tx_ready_in = 0, tx_valid_out, wide_in = 0;
    logic [3:0][15:0] rx_data_in = 0;
    logic irq_out, slow = 0;
    int failures = 0, num_checks = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    pdc_controller dut (.core_clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .mem_read_out,
        .mem_write_out, .mem_address_out, .mem_writedata_out, .mem_wide_out, .mem_readdata_in,
        .mem_waitrequest_in, .rx_valid_in, .rx_data_in, .rx_ready_out, .tx_ready_in,
        .tx_valid_out, .tx_data_out, .wide_in, .irq_out);
    pdc_mem_model mem (.clk_in(core_clk_in), .slow_in(slow), .rd_in(mem_read_out),
        .wr_in(mem_write_out), .addr_in(mem_address_out), .wdata_in(mem_writedata_out),
        .rdata_out(mem_readdata_in), .wait_out(mem_waitrequest_in));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= d;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        q = avs_readdata_out;
        @(posedge core_clk_in);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rdc(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e, "register");
    endtask
    task test_regs;
        rdc({2'h0, PDC_REG_RX_PTR}, PDC_PTR_RESET);
        rdc({2'h3, PDC_REG_TX_CNT}, {16'h0, PDC_CNT_RESET});
        wr({2'h2, PDC_REG_TX_PTR}, 32'hDEADBEE0);
        rdc({2'h2, PDC_REG_TX_PTR}, 32'hDEADBEE0);
        wr({2'h3, 3'h7}, 32'h5A5A5A5A);
        rdc({2'h3, 3'h7}, PDC_READ_ZERO);
        $display("test_regs done");
    endtask
    // Two halfwords from receiver 1 into slow memory; a third word must be refused
    task test_rx;
        int n;
        wide_in <= 4'h2;
        slow <= 1'b1;
        wr({2'h1, PDC_REG_RX_PTR}, 32'h40);
        wr({2'h1, PDC_REG_EVT_ENABLE}, 32'h1);
        wr({2'h1, PDC_REG_RX_CNT}, 32'h2);
        rx_data_in[1] <= 16'h1234;
        rx_valid_in[1] <= 1'b1;
        n = 0;
        for (int i = 0; i < 60; i++) begin
            @(negedge core_clk_in);
            if (rx_ready_out[1] === 1'b1)
                n++;
            @(posedge core_clk_in);
            if (n == 1)
                rx_data_in[1] <= 16'h5678;
        end
        rx_valid_in[1] <= 1'b0;
        chk(n, 2, "rx words");
        chk(mem.mem[8'h40], 16'h1234, "rx mem 0");
        chk(mem.mem[8'h42], 16'h5678, "rx mem 1");
        rdc({2'h1, PDC_REG_RX_PTR}, 32'h44);
        rdc({2'h1, PDC_REG_EVT_STATUS}, 32'h1);
        chk(irq_out, 1'b1, "irq set");
        wr({2'h1, PDC_REG_EVT_CLEAR}, 32'h1);
        // The clear lands on the edge the write task returns at; look once it has settled
        @(negedge core_clk_in);
        chk(irq_out, 1'b0, "irq clear");
        $display("test_rx done");
    endtask
    // Two bytes from memory to the SPI transmitter on its own channel
    task test_tx;
        int n;
        logic [15:0] got [2];
        slow <= 1'b0;
        wr({2'h3, PDC_REG_TX_PTR}, 32'h10);
        wr({2'h3, PDC_REG_EVT_ENABLE}, 32'h2);
        wr({2'h3, PDC_REG_TX_CNT}, 32'h2);
        tx_ready_in[3] <= 1'b1;
        n = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge core_clk_in);
            if (tx_valid_out[3] === 1'b1 && n < 2)
                got[n] = tx_data_out;
            if (tx_valid_out[3] === 1'b1)
                n++;
        end
        chk(n, 2, "tx words");
        chk(got[0], 16'hC010, "tx data 0");
        chk(got[1], 16'hC011, "tx data 1");
        rdc({2'h3, PDC_REG_TX_PTR}, 32'h12);
        rdc({2'h3, PDC_REG_EVT_STATUS}, 32'h2);
        chk(irq_out, 1'b1, "irq tx");
        $display("test_tx done");
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        test_regs();
        test_rx();
        test_tx();
        wrap_up();
    end
    // About 160 cycles of tests; a generous margin before calling it hung
    initial begin
        repeat (5000) @(posedge core_clk_in);
        failures++;
        wrap_up();
    end
endmodule
